// >>> core/dai_core.sv
// Dual converter output pipeline, power modes, capture FIFO and APB slave
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns

// ------------------------------------------------------------------
// Capture FIFO
// ------------------------------------------------------------------
module dai_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
  logic [PW:0]      cnt_r, cnt_nxt;
  logic             room_r, room_nxt;
  logic             push, pop;

  assign push      = in_valid & room_r;
  assign pop       = out_ready & (cnt_r != '0);
  assign in_ready  = room_r;
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rd_r];
  assign level     = cnt_r;

  always_comb begin
    wr_nxt   = push ? PW'((32'(wr_r) + 1) % DEPTH) : wr_r;
    rd_nxt   = pop ? PW'((32'(rd_r) + 1) % DEPTH) : rd_r;
    cnt_nxt  = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    room_nxt = (32'(cnt_nxt) < DEPTH);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_r   <= '0;
      rd_r   <= '0;
      cnt_r  <= '0;
      room_r <= 1'b1;
    end else begin
      wr_r   <= wr_nxt;
      rd_r   <= rd_nxt;
      cnt_r  <= cnt_nxt;
      room_r <= room_nxt;
    end
  end

  // Storage has no reset; only written entries are ever read
  always_ff @(posedge pclk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end
endmodule

// ------------------------------------------------------------------
// Top
// ------------------------------------------------------------------
// Operation
// - Output code five clocks after sampling
// - Nine half-clock stages before output latch
// - Format bit high selects two's complement
// - Sleep stops both quantizers, bias stays
// - Shutdown bit selects full power-down
// - Active-low enable drives both output words
// - Two 10-bit three-state words, bit 9 MSB
// - Both channels sample on rising edge
// - Output valid by next rising edge
// - Power-down holds last converted code
// - Zero is 1000000000 or 0; MSB differs
module dai_core
  import dai_pkg::*;
(
  // APB
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Quantizer results, offset binary
  input  wire dai_pair_t         samp,
  // Three-state output words
  output dai_word_t              chan_a_word,
  output dai_word_t              chan_b_word,
  output logic                   chan_a_oe_n,
  output logic                   chan_b_oe_n,
  // Capture FIFO room
  output logic                   fifo_room
);

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic        setup, done, wr_done, rd_data_done, mapped;
  logic [31:0] rd_mux;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;

  dai_ctrl_t   ctrl_r, ctrl_nxt;
  logic        ovr_r, ovr_nxt;
  dai_state_t  st_r, st_nxt;
  logic [WAKE_W-1:0] wcnt_r, wcnt_nxt;

  dai_pair_t   pipe_r [LAT_CYC];
  dai_pair_t   pipe_nxt [LAT_CYC];
  logic [LAT_CYC-1:0] pv_r, pv_nxt;
  dai_pair_t   out_r, out_nxt;
  logic        oe_n_r, oe_n_nxt;
  logic        adv, push;

  logic        f_room, f_valid;
  dai_pair_t   f_data;
  logic [$clog2(FIFO_DEPTH):0] f_level;

  assign setup        = psel & ~penable;
  assign done         = psel & penable & pready_r;
  assign wr_done      = done & pwrite;
  assign rd_data_done = done & ~pwrite & (paddr == ADDR_DATA);
  assign mapped       = (paddr == ADDR_CTRL) | (paddr == ADDR_STAT) | (paddr == ADDR_DATA);

  always_comb begin
    rd_mux = '0;
    unique case (paddr)
      ADDR_CTRL: rd_mux[CTRL_W-1:0] = ctrl_r;
      ADDR_STAT: begin
        rd_mux[STAT_BUSY_BIT]  = (st_r != ST_RUN);
        rd_mux[STAT_AVAIL_BIT] = f_valid;
        rd_mux[STAT_OVR_BIT]   = ovr_r;
        rd_mux[STAT_LVL_LSB +: $bits(f_level)] = f_level;
      end
      ADDR_DATA: begin
        rd_mux[DATA_A_LSB +: WORD_W] = f_valid ? f_data.a : '0;
        rd_mux[DATA_B_LSB +: WORD_W] = f_valid ? f_data.b : '0;
      end
      default: rd_mux = '0;
    endcase
  end

  // Registered answer: pready rises in the access phase, no further waits
  always_comb begin
    pready_nxt  = setup;
    pslverr_nxt = setup & ~mapped;
    prdata_nxt  = (setup & ~pwrite) ? rd_mux : '0;
    ctrl_nxt    = ctrl_r;
    if (wr_done && paddr == ADDR_CTRL) begin
      ctrl_nxt = dai_ctrl_t'(pwdata[CTRL_W-1:0]);
    end
  end

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt   = st_r;
    wcnt_nxt = wcnt_r;
    unique case (st_r)
      ST_RUN: begin
        if (ctrl_r.full_shutdown) begin
          st_nxt = ST_OFF;
        end else if (ctrl_r.sleep) begin
          st_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (ctrl_r.full_shutdown) begin
          st_nxt = ST_OFF;
        end else if (!ctrl_r.sleep) begin
          st_nxt   = ST_WAKE;
          wcnt_nxt = WAKE_SLEEP_CYC;
        end
      end
      ST_OFF: begin
        if (!ctrl_r.full_shutdown) begin
          st_nxt   = ctrl_r.sleep ? ST_SLEEP : ST_WAKE;
          wcnt_nxt = WAKE_SD_CYC;
        end
      end
      ST_WAKE: begin
        if (ctrl_r.full_shutdown) begin
          st_nxt = ST_OFF;
        end else if (ctrl_r.sleep) begin
          st_nxt = ST_SLEEP;
        end else if (wcnt_r == WAKE_ONE) begin
          st_nxt = ST_RUN;
        end else begin
          wcnt_nxt = wcnt_r - WAKE_ONE;
        end
      end
      default: st_nxt = ST_OFF;
    endcase
  end

  // ----------------------------------------------------------------
  // Conversion pipeline
  // ----------------------------------------------------------------
  // Pairs of the half-clock stages fold into one register per clock
  assign adv  = (st_r == ST_RUN) | (st_r == ST_WAKE);
  assign push = adv & pv_r[LAT_CYC-1];

  always_comb begin
    pipe_nxt = pipe_r;
    pv_nxt   = pv_r;
    out_nxt  = out_r;
    if (adv) begin
      pipe_nxt[0] = samp;
      pv_nxt[0]   = (st_r == ST_RUN);
      for (int i = 1; i < LAT_CYC; i++) begin
        pipe_nxt[i] = pipe_r[i-1];
        pv_nxt[i]   = pv_r[i-1];
      end
      out_nxt = pipe_r[LAT_CYC-1];
      out_nxt.a[MSB] = pipe_r[LAT_CYC-1].a[MSB] ^ ctrl_r.twos_comp;
      out_nxt.b[MSB] = pipe_r[LAT_CYC-1].b[MSB] ^ ctrl_r.twos_comp;
    end
    oe_n_nxt = ctrl_r.out_dis_n;
    // Set wins over the write-one clear
    ovr_nxt = ovr_r;
    if (wr_done && paddr == ADDR_STAT && pwdata[STAT_OVR_BIT]) begin
      ovr_nxt = 1'b0;
    end
    if (push && !f_room) begin
      ovr_nxt = 1'b1;
    end
  end

  // Converter cannot stall; a full FIFO drops the word and flags overrun
  dai_fifo #(
    .WIDTH (PAIR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (push),
    .in_ready  (f_room),
    .in_data   (out_nxt),
    .out_valid (f_valid),
    .out_ready (rd_data_done),
    .out_data  (f_data),
    .level     (f_level)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      ctrl_r    <= CTRL_RST;
      ovr_r     <= 1'b0;
      st_r      <= ST_OFF;
      wcnt_r    <= '0;
      pv_r      <= '0;
      out_r     <= '0;
      oe_n_r    <= 1'b1;
      for (int i = 0; i < LAT_CYC; i++) begin
        pipe_r[i] <= '0;
      end
    end else begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      ctrl_r    <= ctrl_nxt;
      ovr_r     <= ovr_nxt;
      st_r      <= st_nxt;
      wcnt_r    <= wcnt_nxt;
      pv_r      <= pv_nxt;
      out_r     <= out_nxt;
      oe_n_r    <= oe_n_nxt;
      pipe_r    <= pipe_nxt;
    end
  end

  assign prdata      = prdata_r;
  assign pready      = pready_r;
  assign pslverr     = pslverr_r;
  assign chan_a_word = out_r.a;
  assign chan_b_word = out_r.b;
  assign chan_a_oe_n = oe_n_r;
  assign chan_b_oe_n = oe_n_r;
  assign fifo_room   = f_room;
endmodule

// >>> core/dai_pkg.sv
// Constants and carrier types for the dual converter output interface
package dai_pkg;

  // ----------------------------------------------------------------
  // Data path
  // ----------------------------------------------------------------
  localparam int WORD_W      = 10;
  localparam int LAT_CYC     = 5;
  localparam int HALF_STAGES = 9;
  localparam int FIFO_DEPTH  = 4;
  localparam int MSB         = WORD_W - 1;

  typedef logic [WORD_W-1:0] dai_word_t;

  typedef struct packed {
    dai_word_t b;
    dai_word_t a;
  } dai_pair_t;

  localparam int PAIR_W = $bits(dai_pair_t);

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_DATA = 8'h08;

  typedef struct packed {
    logic out_dis_n;
    logic full_shutdown;
    logic sleep;
    logic twos_comp;
  } dai_ctrl_t;

  localparam int        CTRL_W   = $bits(dai_ctrl_t);
  localparam dai_ctrl_t CTRL_RST = 4'h8;

  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_AVAIL_BIT = 1;
  localparam int STAT_OVR_BIT   = 2;
  localparam int STAT_LVL_LSB   = 3;
  localparam int DATA_A_LSB     = 0;
  localparam int DATA_B_LSB     = 16;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS         = 100;
  localparam int WAKE_SLEEP_NS  = 650;
  localparam int WAKE_SD_NS     = 1200;
  localparam int WAKE_W         = 4;
  localparam logic [WAKE_W-1:0] WAKE_SLEEP_CYC =
    WAKE_W'((WAKE_SLEEP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [WAKE_W-1:0] WAKE_SD_CYC =
    WAKE_W'((WAKE_SD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [WAKE_W-1:0] WAKE_ONE = 4'h1;

  typedef enum logic [3:0] {
    ST_RUN   = 4'b0001,
    ST_SLEEP = 4'b0010,
    ST_OFF   = 4'b0100,
    ST_WAKE  = 4'b1000
  } dai_state_t;

endpackage

// >>> test/dai_capture.sv
// Capture side model: resolves the three-state words and registers them
`timescale 1ns/1ns
module dai_capture
  import dai_pkg::*;
(
  // Clock
  input  wire logic      pclk,
  // Device pins
  input  wire dai_word_t chan_a_word,
  input  wire dai_word_t chan_b_word,
  input  wire logic      chan_a_oe_n,
  input  wire logic      chan_b_oe_n,
  // Captured pair
  output dai_pair_t      cap
);
  dai_pair_t last, pin;
  // Released pins show no friendly copy of the last level
  always_comb begin
    pin.a = chan_a_oe_n ? ~last.a : chan_a_word;
    pin.b = chan_b_oe_n ? ~last.b : chan_b_word;
  end
  always @(posedge pclk) begin
    if (!chan_a_oe_n) last.a <= chan_a_word;
    if (!chan_b_oe_n) last.b <= chan_b_word;
    cap <= pin;
  end
endmodule

// >>> test/dai_core_props.sv
// Port checks for the converter output interface
`timescale 1ns/1ns
module dai_core_props
  import dai_pkg::*;
(
  // APB
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Stream
  input wire dai_pair_t         samp,
  input wire dai_word_t         chan_a_word,
  input wire dai_word_t         chan_b_word,
  input wire logic              chan_a_oe_n,
  input wire logic              chan_b_oe_n,
  input wire logic              fifo_room
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // Control shadow
  // ----
  dai_ctrl_t  ctrl_r, ctrl_nxt;
  logic [3:0] run_r, run_nxt, off_r, off_nxt, wr_r, wr_nxt;
  logic       wr_ctrl, idle;
  // Counters give margin for the one-edge lag of the power state
  always_comb begin
    wr_ctrl  = psel && penable && pready && pwrite && paddr == ADDR_CTRL;
    idle     = ctrl_r.sleep || ctrl_r.full_shutdown;
    ctrl_nxt = wr_ctrl ? dai_ctrl_t'(pwdata[CTRL_W-1:0]) : ctrl_r;
    run_nxt  = idle ? 4'h0 : run_r + 4'(run_r != 4'hf);
    off_nxt  = !idle ? 4'h0 : off_r + 4'(off_r != 4'hf);
    wr_nxt   = wr_ctrl ? 4'h0 : wr_r + 4'(wr_r != 4'hf);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
      run_r  <= 4'h0;
      off_r  <= 4'h0;
      wr_r   <= 4'h0;
    end else begin
      ctrl_r <= ctrl_nxt;
      run_r  <= run_nxt;
      off_r  <= off_nxt;
      wr_r   <= wr_nxt;
    end
  end
  a_lat_chan_a: assert property (run_r >= 4'h9 |-> chan_a_word ==
    {$past(samp.a[MSB], 6) ^ $past(ctrl_r.twos_comp), $past(samp.a[MSB-1:0], 6)})
    else $error("channel a word out of its pipeline slot");
  a_lat_chan_b: assert property (run_r >= 4'h9 |-> chan_b_word ==
    {$past(samp.b[MSB], 6) ^ $past(ctrl_r.twos_comp), $past(samp.b[MSB-1:0], 6)})
    else $error("channel b word out of its pipeline slot");
  a_frozen_hold: assert property (off_r >= 4'h4 |->
    $stable(chan_a_word) && $stable(chan_b_word)) else $error("word moved while idle");
  a_oe_follow: assert property (wr_r >= 4'h2 |->
    chan_a_oe_n == ctrl_r.out_dis_n && chan_b_oe_n == ctrl_r.out_dis_n)
    else $error("output enable differs from control");
  a_ready_slot: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_only: assert property (pready |-> psel && penable && $past(psel && !penable))
    else $error("ready outside access");
  a_err_map: assert property (pready |->
    pslverr == (paddr > ADDR_DATA || paddr[1:0] != 2'b00)) else $error("bad error flag");
  a_ctrl_read: assert property (pready && !pwrite && paddr == ADDR_CTRL |->
    prdata == 32'(ctrl_r)) else $error("control read back wrong");
endmodule

// >>> test/test_dai_core.sv
// Self-checking bench for the converter output interface
`timescale 1ns/1ns
module test_dai_core
  import dai_pkg::*;
;
  logic              pclk = 1'b0, presetn = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0]       pwdata = '0, prdata, rd;
  logic              pready, pslverr, err, chan_a_oe_n, chan_b_oe_n, fifo_room;
  dai_pair_t         samp = '0, cap, h;
  dai_pair_t         hist [0:6];
  dai_word_t         chan_a_word, chan_b_word;
  integer            seed = 35082, fails = 0, n_checks = 0, tcnt = 0;
  always #50 pclk = ~pclk;
  dai_core u_dai_core (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .samp(samp), .chan_a_word(chan_a_word),
    .chan_b_word(chan_b_word), .chan_a_oe_n(chan_a_oe_n), .chan_b_oe_n(chan_b_oe_n),
    .fifo_room(fifo_room));
  dai_capture u_dai_capture (.pclk(pclk), .chan_a_word(chan_a_word),
    .chan_b_word(chan_b_word), .chan_a_oe_n(chan_a_oe_n), .chan_b_oe_n(chan_b_oe_n),
    .cap(cap));
  // Random codes with offset zero and full scale mixed in
  always @(posedge pclk) begin
    tcnt <= tcnt + 1;
    samp <= (tcnt % 5 == 0) ? {10'h3ff, 10'h200} : dai_pair_t'(PAIR_W'($random(seed)));
    hist[0] <= samp;
    for (int i = 1; i < 7; i++) hist[i] <= hist[i-1];
    if (tcnt == 3000) begin
      fails = fails + 1;
      complete_run();
    end
  end
  function automatic dai_word_t fmt(input dai_word_t v, input logic t);
    return {v[MSB] ^ t, v[MSB-1:0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("mismatch at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the bench timeout ends a wait that never sees ready
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic stream(input integer n, input logic t);
    repeat (n) begin
      @(negedge pclk);
      chk({12'h0, cap}, {12'h0, fmt(hist[6].b, t), fmt(hist[6].a, t)});
    end
  endtask
  task automatic hold();
    @(negedge pclk);
    h = cap;
    repeat (8) begin
      @(negedge pclk);
      chk({12'h0, cap}, {12'h0, h});
    end
  endtask
  task automatic complete_run();
    if (fails == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, '0);
    chk(rd, 32'(CTRL_RST));
    apb(1'b0, 8'h0c, '0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h0);
    repeat (WAKE_SD_CYC + LAT_CYC + 4) @(posedge pclk);
    stream(24, 1'b0);
    apb(1'b0, ADDR_STAT, '0);
    chk(rd & 32'h7, 32'h6);
    chk({31'h0, fifo_room}, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h1);
    repeat (3) @(posedge pclk);
    stream(24, 1'b1);
    apb(1'b1, ADDR_CTRL, 32'h3);
    repeat (5) @(posedge pclk);
    hold();
    apb(1'b0, ADDR_STAT, '0);
    chk(rd & 32'h1, 32'h1);
    repeat (FIFO_DEPTH) begin
      apb(1'b0, ADDR_DATA, '0);
      chk({31'h0, err}, 32'h0);
      chk(rd & 32'hfc00_fc00, 32'h0);
    end
    apb(1'b0, ADDR_DATA, '0);
    chk(rd, 32'h0);
    apb(1'b0, ADDR_STAT, '0);
    chk(rd & 32'h3e, 32'h4);
    apb(1'b1, ADDR_STAT, 32'h4);
    apb(1'b0, ADDR_STAT, '0);
    chk(rd & 32'h4, 32'h0);
    chk({31'h0, fifo_room}, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h1);
    repeat (WAKE_SLEEP_CYC + LAT_CYC + 4) @(posedge pclk);
    stream(24, 1'b1);
    apb(1'b1, ADDR_CTRL, 32'h4);
    repeat (5) @(posedge pclk);
    hold();
    apb(1'b1, ADDR_CTRL, 32'hc);
    repeat (3) @(negedge pclk);
    chk({30'h0, chan_b_oe_n, chan_a_oe_n}, 32'h3);
    chk({12'h0, cap}, {12'h0, ~h});
    apb(1'b1, ADDR_CTRL, 32'h0);
    repeat (WAKE_SD_CYC + LAT_CYC + 4) @(posedge pclk);
    stream(24, 1'b0);
    complete_run();
  end
endmodule
bind dai_core dai_core_props u_dai_core_props (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .samp(samp),
  .chan_a_word(chan_a_word), .chan_b_word(chan_b_word), .chan_a_oe_n(chan_a_oe_n),
  .chan_b_oe_n(chan_b_oe_n), .fifo_room(fifo_room));
